// ==== logic/flash_pins_pkg.sv ====
package flash_pins_pkg;

    // Timing of the host side reference clock
    localparam int CLK_PERIOD_NS      = 20;
    // Least low time of the hardware reset lane, and its count in clock cycles (rounded up)
    localparam int RESET_PULSE_MIN_NS = 1000;
    localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Frame geometry
    localparam int INSTR_BITS = 8;
    localparam int ADDR_BITS  = 24;
    localparam int BYTE_BITS  = 8;

    // Byte sent when the host reads faster than the user side supplies data
    localparam logic [7:0] FILL_BYTE = 8'hFF;

    // Output enable masks per lane width
    localparam logic [3:0] OE_MASK_W1 = 4'h2;
    localparam logic [3:0] OE_MASK_W2 = 4'h3;
    localparam logic [3:0] OE_MASK_W4 = 4'hF;

    // Index of the shared lanes and of the pin groups in the synchroniser
    localparam int LANE_WP       = 2;
    localparam int LANE_HOLD_RST = 3;
    localparam int PIN_SCLK      = 4;
    localparam int PIN_CS        = 5;

    typedef enum logic [1:0] {
        LW1,
        LW2,
        LW4
    } lane_width_t;

    // Phase plan of one command, answered by the user side per instruction
    typedef struct packed {
        logic        has_addr;
        lane_width_t addr_lanes;
        logic [4:0]  dummy_clks;
        logic        has_data;
        logic        data_out;
        lane_width_t data_lanes;
    } phase_cfg_t;

    // What the device has collected from the host in the current frame
    typedef struct packed {
        logic [7:0]  instr;
        logic [23:0] addr;
    } frame_info_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INSTR,
        ST_DECODE,
        ST_ADDR,
        ST_DUMMY,
        ST_DIN,
        ST_DOUT,
        ST_WAIT
    } phase_t;

endpackage

// ==== logic/flash_pin_if.sv ====
`timescale 1ns/1ns
// Contract
// [R1] Single mode: instruction, address and data sampled on lane 0 at clock rise.
// [R2] Read data changes on the output lane at each clock fall.
// [R3] Dual/quad: lanes 0 and 1 bidirectional, sample on rise, drive on fall.
// [R4] Standard and dual use lanes 0-1; quad uses lanes 0-3.
// [R5] Chip select high: deselected, every data output released.
// [R6] After power-up a select high-to-low edge is needed before any instruction.
// [R7] Write-protect lane can block status writes together with protect bits.
// [R8] Quad enabled: lane 2 is data only, write protect ignored.
// [R9] Select bit 0 (default): lane 3 is an active-low hold input.
// [R10] Hold low while selected: outputs float, input and clock ignored, then resume.
// [R11] Quad enabled: hold function unavailable, lane 3 is data only.
// [R12] Select bit 1 and quad off: lane 3 is an active-low hardware reset.
// [R13] Reset held low about 1us aborts any operation regardless of other pins.
// [R14] Quad enabled: lane 3 is data, hardware reset unavailable.
// [R15] Continuous read: 24-bit address read with as few as eight clocks overhead.
// [R16] Lane drivers enabled only during output phases of a selected command.
module flash_pin_if
    import flash_pins_pkg::*;
(
    input  wire logic        ref_clk,               // System clock, 50 MHz
    input  wire logic        rst,                   // Synchronous reset, active high
    input  wire logic        serial_clk_pin,        // Serial clock from the host
    input  wire logic        chip_sel_n_pin,        // Chip select from the host, active low
    input  wire logic [3:0]  data_lane_in,          // Lane levels seen on the pins
    output logic      [3:0]  data_lane_out,         // Lane levels driven by the device
    output logic      [3:0]  data_lane_oe,          // Lane drive enables, high drives
    input  wire logic        quad_enable,           // Quad lanes enabled
    input  wire logic        pause_or_reset_select, // Lane 3: 0 hold, 1 hardware reset
    input  wire logic        status_protect_bit,    // Status protect setting
    input  wire logic        cont_read_mode,        // Next frame skips the instruction
    input  wire phase_cfg_t  cmd_cfg,               // Phase plan for frame.instr
    output logic             instr_valid,           // Instruction taken, cmd_cfg sampled
    output logic             addr_valid,            // Address complete, one cycle
    output frame_info_t      frame,                 // Instruction and address
    output logic             rx_valid,              // Received data byte, one cycle
    output logic      [7:0]  rx_data,               // Received data byte
    input  wire logic        tx_valid,              // Read data offered
    input  wire logic [7:0]  tx_data,               // Read data byte
    output logic             tx_ready,              // Buffer has room
    output logic             tx_underrun,           // Fill byte sent, one cycle
    output logic             selected,              // Chip select seen low
    output logic             hold_active,           // Device paused by hold
    output logic             hw_reset_pulse,        // Hardware reset taken, one cycle
    output logic             status_write_block     // Status register writes blocked
);

    logic [5:0]  pin_s1_r;
    logic [5:0]  pin_s2_r;
    logic        sclk_prev_r;
    logic        cs_prev_r;
    logic [3:0]  lane_s;
    logic        cs_s;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        hold_now;
    logic        rst_lane_low;
    logic        abort;
    logic        step_rise;
    logic        step_fall;
    phase_t      state_r;
    phase_cfg_t  cfg_r;
    logic [23:0] in_sh_r;
    logic [4:0]  bit_cnt_r;
    logic [4:0]  bit_next;
    lane_width_t in_w;
    logic [2:0]  out_cnt_r;
    logic [7:0]  out_sh_r;
    logic [7:0]  out_cur;
    logic [3:0]  oe_want_r;
    logic [$clog2(RESET_PULSE_MIN_CYC+1)-1:0] rst_cnt_r;
    logic [7:0]  buf_r [2];
    logic        wr_ptr_r;
    logic        rd_ptr_r;
    logic [1:0]  fill_r;
    logic        push;
    logic        pop;
    logic        flush;

    function automatic logic [4:0] lane_step(lane_width_t w);
        case (w)
            LW2:     return 5'd2;
            LW4:     return 5'd4;
            default: return 5'd1;
        endcase
    endfunction

    function automatic logic [23:0] shift_in(logic [23:0] v, lane_width_t w, logic [3:0] l);
        case (w)
            LW2:     return {v[21:0], l[1:0]};
            LW4:     return {v[19:0], l[3:0]};
            default: return {v[22:0], l[0]};
        endcase
    endfunction

    function automatic phase_t data_phase(phase_cfg_t c);
        if (!c.has_data) return ST_WAIT;
        if (c.data_out) return ST_DOUT;
        return ST_DIN;
    endfunction

    function automatic phase_t after_addr(phase_cfg_t c);
        if (c.dummy_clks != 5'd0) return ST_DUMMY;
        return data_phase(c);
    endfunction

    // Pins come from the host's domain; only pin_s2_r is read by logic
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_s1_r <= 6'h00;
            pin_s2_r <= 6'h00;
        end else begin
            pin_s1_r <= {chip_sel_n_pin, serial_clk_pin, data_lane_in};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Select history starts low, so a select already low at reset is no edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_prev_r <= 1'b0;
            cs_prev_r   <= 1'b0;
        end else begin
            sclk_prev_r <= pin_s2_r[PIN_SCLK];
            cs_prev_r   <= pin_s2_r[PIN_CS];
        end
    end

    assign lane_s    = pin_s2_r[3:0];
    assign cs_s      = pin_s2_r[PIN_CS];
    assign sclk_rise = pin_s2_r[PIN_SCLK] & ~sclk_prev_r;
    assign sclk_fall = ~pin_s2_r[PIN_SCLK] & sclk_prev_r;
    assign cs_fall   = cs_prev_r & ~cs_s;                                   // R6
    assign cs_rise   = ~cs_prev_r & cs_s;

    assign selected = ~cs_s;
    assign hold_now = ~cs_s & ~quad_enable & ~pause_or_reset_select
                      & ~lane_s[LANE_HOLD_RST];                             // R9 R11
    assign hold_active  = hold_now;
    assign rst_lane_low = pause_or_reset_select & ~quad_enable
                          & ~lane_s[LANE_HOLD_RST];                         // R12 R14
    assign status_write_block = status_protect_bit & ~quad_enable
                                & ~lane_s[LANE_WP];                         // R7 R8

    // Clock edges while held are ignored
    assign step_rise = sclk_rise & ~hold_now & ~cs_s;                       // R10
    assign step_fall = sclk_fall & ~hold_now & ~cs_s;                       // R10

    // Reset lane low-time counter; it saturates so one long pulse aborts once
    always_ff @(posedge ref_clk) begin
        if (rst || !rst_lane_low) begin
            rst_cnt_r <= '0;
        end else if (rst_cnt_r != RESET_PULSE_MIN_CYC[$bits(rst_cnt_r)-1:0]) begin
            rst_cnt_r <= rst_cnt_r + 1'b1;
        end
    end
    assign abort = rst_lane_low
                   && rst_cnt_r == RESET_PULSE_MIN_CYC[$bits(rst_cnt_r)-1:0] - 1'b1; // R13
    assign hw_reset_pulse = abort;

    assign in_w     = (state_r == ST_ADDR) ? cfg_r.addr_lanes
                    : (state_r == ST_DIN) ? cfg_r.data_lanes : LW1;
    assign bit_next = bit_cnt_r + lane_step(in_w);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else if (abort || cs_s) begin
            state_r <= ST_IDLE;                                             // R13 R5
        end else if (state_r == ST_IDLE) begin
            if (cs_fall) begin
                state_r <= cont_read_mode ? ST_ADDR : ST_INSTR;             // R6 R15
            end
        end else if (state_r == ST_DECODE) begin
            state_r <= cmd_cfg.has_addr ? ST_ADDR : after_addr(cmd_cfg);
        end else if (step_rise) begin
            case (state_r)
                ST_INSTR: begin
                    if (bit_next == 5'(INSTR_BITS)) begin
                        state_r <= ST_DECODE;
                    end
                end
                ST_ADDR: begin
                    if (bit_next == 5'(ADDR_BITS)) begin
                        state_r <= after_addr(cfg_r);
                    end
                end
                ST_DUMMY: begin
                    if (bit_next == cfg_r.dummy_clks) begin
                        state_r <= data_phase(cfg_r);
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // Input shifting and bit counting, all on sampled rising edges
    always_ff @(posedge ref_clk) begin
        if (rst || cs_s || state_r == ST_IDLE || state_r == ST_DECODE) begin
            bit_cnt_r <= 5'd0;
            in_sh_r   <= 24'h00_0000;
        end else if (step_rise) begin
            in_sh_r <= shift_in(in_sh_r, in_w, lane_s);                     // R1 R3 R4
            if (state_r == ST_DIN && bit_next == 5'(BYTE_BITS)) begin
                bit_cnt_r <= 5'd0;
            end else if (state_r == ST_ADDR && bit_next == 5'(ADDR_BITS)) begin
                bit_cnt_r <= 5'd0;
            end else begin
                bit_cnt_r <= bit_next;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_r <= '0;
        end else if (state_r == ST_DECODE) begin
            cfg_r <= cmd_cfg;
        end
    end

    // Frame contents and the one-cycle receive strobes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            frame      <= '0;
            addr_valid <= 1'b0;
            rx_valid   <= 1'b0;
            rx_data    <= 8'h00;
        end else begin
            addr_valid <= 1'b0;
            rx_valid   <= 1'b0;
            if (step_rise && !abort) begin
                if (state_r == ST_INSTR && bit_next == 5'(INSTR_BITS)) begin
                    frame.instr <= {in_sh_r[6:0], lane_s[0]};               // R1
                end
                if (state_r == ST_ADDR && bit_next == 5'(ADDR_BITS)) begin
                    frame.addr <= shift_in(in_sh_r, in_w, lane_s);
                    addr_valid <= 1'b1;
                end
                if (state_r == ST_DIN && bit_next == 5'(BYTE_BITS)) begin
                    rx_data  <= 8'(shift_in(in_sh_r, in_w, lane_s));
                    rx_valid <= 1'b1;
                end
            end
        end
    end
    assign instr_valid = (state_r == ST_DECODE);

    // Two-entry read buffer; the host cannot be stalled, so an empty
    // buffer at a byte boundary sends the fill byte instead
    assign tx_ready = (fill_r != 2'd2);
    assign push     = tx_valid & tx_ready;
    assign flush    = cs_rise | abort;
    assign pop      = step_fall && state_r == ST_DOUT && out_cnt_r == 3'd0 && fill_r != 2'd0;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            buf_r[wr_ptr_r] <= tx_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || flush) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            fill_r   <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            fill_r <= fill_r + {1'b0, push} - {1'b0, pop};
        end
    end

    assign out_cur = (out_cnt_r != 3'd0) ? out_sh_r
                   : (fill_r != 2'd0) ? buf_r[rd_ptr_r] : FILL_BYTE;

    // Output shifting on sampled falling edges
    always_ff @(posedge ref_clk) begin
        if (rst || cs_s || abort) begin
            out_cnt_r     <= 3'd0;
            out_sh_r      <= 8'h00;
            data_lane_out <= 4'h0;
            oe_want_r     <= 4'h0;
            tx_underrun   <= 1'b0;
        end else begin
            tx_underrun <= 1'b0;
            if (step_fall && state_r == ST_DOUT) begin                      // R2 R3
                out_sh_r  <= out_cur << lane_step(cfg_r.data_lanes);
                out_cnt_r <= out_cnt_r + 3'(lane_step(cfg_r.data_lanes));
                tx_underrun <= (out_cnt_r == 3'd0) && (fill_r == 2'd0);
                case (cfg_r.data_lanes)                                     // R4
                    LW2: begin
                        data_lane_out <= {2'b00, out_cur[7:6]};
                        oe_want_r     <= OE_MASK_W2;
                    end
                    LW4: begin
                        data_lane_out <= out_cur[7:4];
                        oe_want_r     <= OE_MASK_W4;
                    end
                    default: begin
                        data_lane_out <= {2'b00, out_cur[7], 1'b0};
                        oe_want_r     <= OE_MASK_W1;
                    end
                endcase
            end
        end
    end

    // Drivers stay released while held, so a held bit is presented again on resume
    always_ff @(posedge ref_clk) begin
        if (rst || cs_s || hold_now || abort || state_r != ST_DOUT) begin
            data_lane_oe <= 4'h0;                                           // R5 R10 R16
        end else begin
            data_lane_oe <= oe_want_r;                                      // R16
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Select high is already folded into step_rise
    sequence s_instr_done;
        state_r == ST_INSTR && step_rise && !abort && bit_next == 5'(INSTR_BITS);
    endsequence
    sequence s_decode_once;
        state_r == ST_DECODE ##1 state_r != ST_DECODE;
    endsequence

    a_deselect_release: assert property (cs_s |=> data_lane_oe == 4'h0) // R5
        else $error("lane driven while deselected");
    a_instr_sampled: assert property (s_instr_done |=> s_decode_once) // R1
        else $error("instruction byte not decoded");
    a_fall_drives: assert property ($changed(data_lane_out) // R2
                                    |-> $past(sclk_fall) || $past(cs_s) || $past(abort))
        else $error("output lane changed off a falling edge");
    a_dual_lanes: assert property (data_lane_oe != 4'h0 && cfg_r.data_lanes == LW2 // R3
                                   |-> data_lane_oe == OE_MASK_W2)
        else $error("dual read not on lanes 0 and 1");
    a_quad_only_upper: assert property (data_lane_oe[3] || data_lane_oe[2] // R4
                                        |-> cfg_r.data_lanes == LW4)
        else $error("upper lanes driven outside quad");
    a_start_needs_edge: assert property ($rose(state_r == ST_INSTR) |-> $past(cs_fall)) // R6
        else $error("instruction started without select edge");
    a_quad_no_protect: assert property (quad_enable |-> !status_write_block && !hold_now) // R8
        else $error("shared lane function active in quad mode");
    // Decode clears the counter by design, so it is left out
    a_hold_freezes: assert property (hold_now && state_r != ST_IDLE // R10
                                     && state_r != ST_DECODE
                                     |=> $stable(bit_cnt_r) && data_lane_oe == 4'h0)
        else $error("device moved while held");
    a_reset_aborts: assert property (hw_reset_pulse |-> rst_lane_low ##1 state_r == ST_IDLE // R13
                                     && data_lane_oe == 4'h0)
        else $error("hardware reset did not abort");
    a_reset_waits: assert property ($rose(rst_lane_low) |-> !hw_reset_pulse [*8]) // R13
        else $error("hardware reset taken too early");
    a_cont_skips: assert property (state_r == ST_IDLE && cs_fall && cont_read_mode // R15
                                   && !abort |=> state_r == ST_ADDR)
        else $error("continuous read did not skip instruction");
    a_oe_output_only: assert property (data_lane_oe != 4'h0 |-> state_r == ST_DOUT) // R16
        else $error("driver enabled outside an output phase");
endmodule

// ==== verification/spi_host_model.sv ====
`timescale 1ns/1ns
module spi_host_model (
    input  wire logic       ref_clk, // Bench clock, host steps on its fall
    input  wire logic [3:0] lanes,   // Resolved lane levels
    input  wire logic [3:0] dut_oe,  // Device drive enables
    output logic            sclk,    // Serial clock, idle low
    output logic            cs_n,    // Select, active low
    output logic      [3:0] h_out,   // Host lane levels
    output logic      [3:0] h_oe     // Host drive enables
);
    logic [3:0] drv_oe  = 4'h0;
    logic [3:0] drv_out = 4'h0;
    logic [1:0] pin_low = 2'h0; // Lanes 3..2 pulled low by the bench
    logic [3:0] oe_seen = 4'h0; // Device enables seen while reading
    int         clash   = 0;    // Cycles where both sides drove one lane

    assign h_oe  = drv_oe | {pin_low, 2'h0};
    assign h_out = drv_out & ~{pin_low, 2'h0};

    initial begin
        sclk = 1'h0;
        cs_n = 1'h0;
    end

    always @(negedge ref_clk) begin
        if (|(dut_oe & h_oe)) begin
            clash++;
        end
    end

    // Clock stays high at the select rise so no stray fall reaches a selected device
    task automatic sel(input logic v);
        @(negedge ref_clk);
        cs_n   = v;
        drv_oe = 4'h0;
        repeat (4) @(negedge ref_clk);
        sclk = 1'h0;
        repeat (6) @(negedge ref_clk);
    endtask

    // Drives after each fall, samples read bits just before the next fall
    task automatic xfer(input int w, input int n, input logic wr,
                        input logic [31:0] din, output logic [31:0] dout);
        logic [3:0] m;
        m    = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
        dout = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            sclk    = 1'h0;
            drv_oe  = wr ? m : 4'h0;
            drv_out = 4'(din >> (i * w)) & m;
            repeat (5) @(negedge ref_clk);
            sclk = 1'h1;
            repeat (3) @(negedge ref_clk);
            if (!wr) begin
                oe_seen = oe_seen | dut_oe;
                dout    = (dout << w) | 32'((w == 1) ? {3'h0, lanes[1]} : lanes & m);
            end
        end
    endtask
endmodule

// ==== verification/serial_flash_pin_interface_bench.sv ====
`timescale 1ns/1ns
module serial_flash_pin_interface_bench;
    import flash_pins_pkg::*;

    localparam logic [7:0] OP_WR  = 8'h5C;
    localparam logic [7:0] OP_RD1 = 8'hA1;
    localparam logic [7:0] OP_RD2 = 8'hA2;
    localparam logic [7:0] OP_RD4 = 8'hA4;

    logic        ref_clk, rst, tog, quad_en, prs, spb, cont, tx_valid;
    logic [7:0]  tx_data, rx_data, last_rx;
    logic [3:0]  lanes, dut_out, dut_oe, h_out, h_oe;
    logic        sclk, cs_n, instr_valid, addr_valid, rx_valid, tx_ready;
    logic        tx_underrun, selected, hold_active, hw_reset_pulse, swb;
    logic [31:0] d;
    phase_cfg_t  cfg;
    frame_info_t frame;
    int          fail_count = 0, comparisons = 0;
    int          n_instr = 0, n_rst = 0, n_und = 0, n_hold = 0, n_addr = 0;

    // Released lanes 0/1 toggle so a stale bit never reads as valid; 2/3 have pull-ups
    assign lanes = (dut_oe & dut_out) | (~dut_oe & h_oe & h_out)
                 | (~dut_oe & ~h_oe & {2'h3, tog, ~tog});

    always_comb begin
        case (frame.instr)
            OP_WR:   cfg = '{1'h1, LW1, 5'h00, 1'h1, 1'h0, LW1};
            OP_RD1:  cfg = '{1'h1, LW1, 5'h00, 1'h1, 1'h1, LW1};
            OP_RD2:  cfg = '{1'h1, LW2, 5'h08, 1'h1, 1'h1, LW2};
            OP_RD4:  cfg = '{1'h1, LW4, 5'h06, 1'h1, 1'h1, LW4};
            default: cfg = '{1'h0, LW1, 5'h00, 1'h0, 1'h0, LW1};
        endcase
    end

    initial begin
        ref_clk = 1'h0;
        forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        tog <= rst ? 1'h0 : ~tog;
        if (!rst) begin
            n_addr  <= n_addr + int'(addr_valid === 1'h1);
            n_instr <= n_instr + int'(instr_valid === 1'h1);
            n_rst   <= n_rst + int'(hw_reset_pulse === 1'h1);
            n_und   <= n_und + int'(tx_underrun === 1'h1);
            n_hold  <= n_hold + int'(hold_active === 1'h1 && quad_en);
            if (rx_valid === 1'h1) begin
                last_rx <= rx_data;
            end
        end
    end

    flash_pin_if DUT (
        .ref_clk(ref_clk), .rst(rst), .serial_clk_pin(sclk), .chip_sel_n_pin(cs_n),
        .data_lane_in(lanes), .data_lane_out(dut_out), .data_lane_oe(dut_oe),
        .quad_enable(quad_en), .pause_or_reset_select(prs), .status_protect_bit(spb),
        .cont_read_mode(cont), .cmd_cfg(cfg), .instr_valid(instr_valid),
        .addr_valid(addr_valid), .frame(frame), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .tx_underrun(tx_underrun), .selected(selected), .hold_active(hold_active),
        .hw_reset_pulse(hw_reset_pulse), .status_write_block(swb)
    );

    spi_host_model host (
        .ref_clk(ref_clk), .lanes(lanes), .dut_oe(dut_oe), .sclk(sclk),
        .cs_n(cs_n), .h_out(h_out), .h_oe(h_oe)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic set_mode(input logic q, input logic p, input logic s, input logic c);
        quad_en = q;
        prs     = p;
        spb     = s;
        cont    = c;
    endtask

    task automatic push(input logic [7:0] b);
        @(negedge ref_clk);
        tx_valid = 1'h1;
        tx_data  = b;
        @(negedge ref_clk);
        tx_valid = 1'h0;
    endtask

    task automatic cmd(input logic [7:0] op, input int aw, input logic [23:0] a);
        host.sel(1'h0);
        host.xfer(1, 8, 1'h1, {24'h0, op}, d);
        host.xfer(aw, 24 / aw, 1'h1, {8'h0, a}, d);
    endtask

    task automatic rdchk(input int w, input logic [7:0] exp);
        host.xfer(w, 8 / w, 1'h0, 32'h0, d);
        check(d, {24'h0, exp});
    endtask

    task automatic end_sim();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #200_000;
        fail_count++;
        end_sim();
    end

    initial begin
        rst = 1'h1;
        set_mode(1'h0, 1'h0, 1'h0, 1'h0);
        tx_valid = 1'h0;
        tx_data = 8'h00;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'h0;
        check(dut_oe, 4'h0);
        host.xfer(1, 8, 1'h1, {24'h0, OP_WR}, d);
        settle(6);
        check(n_instr, 0);
        host.sel(1'h1);
        cmd(OP_WR, 1, 24'h12_3456);
        host.xfer(1, 8, 1'h1, 32'h0000_00A5, d);
        settle(4);
        check(frame.addr, 24'h12_3456);
        check(last_rx, 8'hA5);
        check(selected, 1'h1);
        host.sel(1'h1);
        // Clocks while paused carry zeros that must not reach the byte
        cmd(OP_WR, 1, 24'h00_0001);
        host.pin_low = 2'h2;
        settle(4);
        check(hold_active, 1'h1);
        host.xfer(1, 4, 1'h1, 32'h0, d);
        host.pin_low = 2'h0;
        host.xfer(1, 8, 1'h1, 32'h0000_003C, d);
        settle(4);
        check(last_rx, 8'h3C);
        host.sel(1'h1);
        push(8'hA1);
        push(8'hB2);
        check(tx_ready, 1'h0);
        push(8'hC3);
        host.oe_seen = 4'h0;
        cmd(OP_RD1, 1, 24'h00_0010);
        rdchk(1, 8'hA1);
        rdchk(1, 8'hB2);
        rdchk(1, FILL_BYTE);
        check(n_und, 1);
        check(host.oe_seen, 4'h2);
        host.sel(1'h1);
        check(dut_oe, 4'h0);
        check(selected, 1'h0);
        check(tx_ready, 1'h1);
        push(8'h96);
        host.oe_seen = 4'h0;
        cmd(OP_RD2, 2, 24'h00_0020);
        host.xfer(1, 8, 1'h0, 32'h0, d);
        rdchk(2, 8'h96);
        check(frame.addr, 24'h00_0020);
        check(host.oe_seen, 4'h3);
        host.sel(1'h1);
        set_mode(1'h1, 1'h0, 1'h0, 1'h0);
        push(8'h5A);
        host.oe_seen = 4'h0;
        cmd(OP_RD4, 4, 24'h00_F0F0);
        check(n_hold, 0);
        host.xfer(4, 6, 1'h0, 32'h0, d);
        rdchk(4, 8'h5A);
        check(host.oe_seen, 4'hF);
        check(host.clash, 0);
        host.sel(1'h1);
        push(8'h7E);
        set_mode(1'h1, 1'h0, 1'h0, 1'h1);
        host.sel(1'h0);
        host.xfer(4, 6, 1'h1, 32'h0012_3ABC, d);
        host.xfer(4, 6, 1'h0, 32'h0, d);
        rdchk(4, 8'h7E);
        check(frame.addr, 24'h12_3ABC);
        check(n_instr, 5);
        check(n_addr, 6);
        host.sel(1'h1);
        set_mode(1'h1, 1'h0, 1'h1, 1'h0);
        host.pin_low = 2'h1;
        settle(4);
        check(swb, 1'h0);
        set_mode(1'h0, 1'h0, 1'h1, 1'h0);
        settle(4);
        check(swb, 1'h1);
        host.pin_low = 2'h0;
        settle(4);
        check(swb, 1'h0);
        set_mode(1'h1, 1'h1, 1'h1, 1'h0);
        host.pin_low = 2'h2;
        settle(60);
        check(n_rst, 0);
        host.pin_low = 2'h0;
        settle(4);
        set_mode(1'h0, 1'h1, 1'h1, 1'h0);
        host.pin_low = 2'h2;
        settle(40);
        host.pin_low = 2'h0;
        settle(4);
        check(n_rst, 0);
        host.sel(1'h0);
        host.xfer(1, 4, 1'h1, 32'h0000_000A, d);
        host.pin_low = 2'h2;
        settle(60);
        check(n_rst, 1);
        host.pin_low = 2'h0;
        host.xfer(1, 12, 1'h1, 32'h0000_0A1F, d);
        check(n_instr, 5);
        host.sel(1'h1);
        end_sim();
    end
endmodule
